/* File: hdl/lsebf_pkg.sv */
// Constants, encodings and states for the LIN/UART status, error and buffer block.
// Assumes a serializer outside that reports bits, bytes and frame events as pulses.
// How it works
// - Header end sets header done, LIN only
// - Rx response end with good checksum or UART char sets rx done
// - Tx response end or UART char sets tx done
// - Error summary is OR of eight flags
// - Readback mismatch sets bit error, aborts send in LIN mode only
// - Received checksum mismatch sets checksum error
// - Bad identifier parity flagged, never corrected
// - Slave flags synch field out of tolerance
// - Dominant stop bit sets framing error
// - Frame longer than maximum sets timeout error
// - Busy non-abort command or UART overwrite: overrun
// - Abort command while busy sets abort flag
// - Any LIN error returns to idle, abort
// - Clearing summary clears all error flags
// - Break in data aborts; slave flags error
// - Enhanced sum includes identifier, classic excludes
// - Flags gated into error and completion requests
// - Identifier status reports identifiers 3C to 3F
// - Identifier inclusion latched at response command
// - Byte n at index n, autoincrement wraps
// - UART data port is a single register
// - Busy held while communicating, cleared after
// - Done flags clear only by writing one
// - UART data port read clears error summary
package lsebf_pkg;
   localparam int CMD_W = 3;
   localparam int LEN_W = 4;
   localparam int IDX_W = 3;
   localparam logic [2:0] CMD_ABORT = 3'h0;
   localparam logic [2:0] CMD_TX_HDR = 3'h1;
   localparam logic [2:0] CMD_RX_RSP = 3'h2;
   localparam logic [2:0] CMD_TX_RSP = 3'h3;
   localparam int CMD_UART_BIT = 2;
   localparam int CMD_RXEN_BIT = 1;
   localparam int CMD_TXEN_BIT = 0;
   localparam int ERR_BIT = 0;
   localparam int ERR_CK = 1;
   localparam int ERR_PAR = 2;
   localparam int ERR_SYNC = 3;
   localparam int ERR_FRM = 4;
   localparam int ERR_TO = 5;
   localparam int ERR_OVR = 6;
   localparam int ERR_ABORT = 7;
   localparam logic [3:0] ID_SPECIAL_HI = 4'hF;
   localparam logic [7:0] CK_OK = 8'hFF;
   localparam logic [3:0] LEN_MAX = 4'h8;
   localparam logic [3:0] LEN_2 = 4'h2;
   localparam logic [3:0] LEN_4 = 4'h4;
   localparam logic [3:0] LEN_8 = 4'h8;
   localparam logic DOMINANT = 1'b0;
   localparam int TIMEOUT_BITS = 174;
   typedef enum logic [2:0] {ST_IDLE, ST_TX_HDR, ST_RX_RSP, ST_TX_RSP, ST_UART_TX} lsebf_state_type;
endpackage : lsebf_pkg

/* File: hdl/lsebf_core.sv */
// Status flags, error flags, checksum, identifier status and frame buffer.
// Assumes all inputs synchronous to sys_clk; event inputs are one-cycle pulses.
`timescale 1ns/100ps
module lsebf_core #(
   parameter int TIMEOUT_BITS = lsebf_pkg::TIMEOUT_BITS
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic uart_mode,
   input wire logic master_mode,
   input wire logic classic_version_select,
   input wire logic cmd_write,
   input wire logic [lsebf_pkg::CMD_W-1:0] cmd_code,
   input wire logic len_write,
   input wire logic [7:0] len_wdata,
   input wire logic sel_write,
   input wire logic [lsebf_pkg::IDX_W-1:0] sel_index,
   input wire logic autoinc_disable_n,
   input wire logic dp_write,
   input wire logic [7:0] dp_wdata,
   input wire logic dp_read,
   input wire logic clr_header_done,
   input wire logic clr_rx_done,
   input wire logic clr_tx_done,
   input wire logic clr_error,
   input wire logic error_irq_enable,
   input wire logic header_irq_enable,
   input wire logic tx_irq_enable,
   input wire logic rx_irq_enable,
   input wire logic header_end,
   input wire logic [7:0] header_pid,
   input wire logic sync_bad,
   input wire logic brk_detect,
   input wire logic bit_tick,
   input wire logic tx_bit_valid,
   input wire logic tx_bit_sent,
   input wire logic tx_bit_read,
   input wire logic stop_valid,
   input wire logic stop_level,
   input wire logic rx_byte_valid,
   input wire logic [7:0] rx_byte,
   input wire logic tx_resp_end,
   input wire logic uart_tx_char,
   input wire logic tx_ready,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_abort,
   output logic dp_wr_ready,
   output logic [7:0] dp_rdata,
   output logic header_done_flag,
   output logic rx_done_flag,
   output logic tx_done_flag,
   output logic error_summary_flag,
   output logic [7:0] error_flags_reg,
   output logic [2:0] id_status_field,
   output logic busy_flag,
   output logic [lsebf_pkg::CMD_W-1:0] command_field,
   output logic [lsebf_pkg::LEN_W-1:0] rx_length_field,
   output logic [lsebf_pkg::LEN_W-1:0] tx_length_field,
   output logic [lsebf_pkg::IDX_W-1:0] buffer_index,
   output logic irq_err,
   output logic irq_tc
);
   import lsebf_pkg::*;
   function automatic logic [7:0] add_carry(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0] + {7'h00, s[8]};
   endfunction : add_carry
   lsebf_state_type state;
   logic [7:0] frame_buf [0:7];
   logic [7:0] pid;
   logic [7:0] sum;
   logic [3:0] rx_cnt;
   logic [3:0] feed_cnt;
   logic ck_pushed;
   logic [7:0] uart_rx_data;
   logic uart_unread;
   logic frame_wait;
   logic [15:0] to_cnt;
   logic [7:0] fifo_mem [0:1];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] fifo_cnt;
   // Handshake and event decoding
   wire cmd_is_abort = cmd_code == CMD_ABORT;
   wire cmd_busy = cmd_write & busy_flag;
   wire abort_set = cmd_busy & cmd_is_abort;
   wire ovr_cmd = cmd_busy & ~cmd_is_abort;
   wire cmd_start = cmd_write & ~busy_flag & ~uart_mode;
   wire in_rx = state == ST_RX_RSP;
   wire in_tx_rsp = state == ST_TX_RSP;
   wire tx_phase = (state == ST_TX_HDR) | in_tx_rsp | (state == ST_UART_TX);
   wire fifo_in_ready = fifo_cnt != 2'h2;
   wire lin_dp = (dp_read | dp_write) & ~uart_mode;
   wire uart_tx_en = command_field[CMD_UART_BIT] & command_field[CMD_TXEN_BIT];
   wire uart_push = uart_mode & dp_write & uart_tx_en & ~busy_flag & fifo_in_ready;
   wire rx_data_byte = rx_byte_valid & in_rx & (rx_cnt < rx_length_field);
   wire rx_ck_byte = rx_byte_valid & in_rx & ~(rx_cnt < rx_length_field);
   wire ck_bad = add_carry(sum, rx_byte) != CK_OK;
   wire feed_push = in_tx_rsp & ~ck_pushed & fifo_in_ready;
   wire feed_data = feed_cnt < tx_length_field;
   wire [7:0] feed_byte = feed_data ? frame_buf[feed_cnt[2:0]] : ~sum;
   wire fifo_push = feed_push | uart_push;
   wire [7:0] fifo_wdata = uart_mode ? dp_wdata : feed_byte;
   wire fifo_pop = tx_valid & tx_ready;
   wire par0 = header_pid[0] ^ header_pid[1] ^ header_pid[2] ^ header_pid[4];
   wire par1 = ~(header_pid[1] ^ header_pid[3] ^ header_pid[4] ^ header_pid[5]);
   wire par_bad = {par1, par0} != header_pid[7:6];
   wire slave_brk = brk_detect & ~master_mode & ~uart_mode;
   wire to_hit = frame_wait & bit_tick & (in_rx | in_tx_rsp)
                 & (to_cnt == 16'(TIMEOUT_BITS - 1));
   logic [7:0] err_set;
   assign err_set[ERR_BIT] = (tx_bit_valid & tx_phase & (tx_bit_read != tx_bit_sent))
                             | (slave_brk & in_tx_rsp);
   assign err_set[ERR_CK] = rx_ck_byte & ck_bad;
   assign err_set[ERR_PAR] = header_end & ~uart_mode & par_bad;
   assign err_set[ERR_SYNC] = sync_bad & ~master_mode & ~uart_mode;
   assign err_set[ERR_FRM] = (stop_valid & (stop_level == DOMINANT))
                             | (slave_brk & in_rx);
   assign err_set[ERR_TO] = to_hit;
   assign err_set[ERR_OVR] = ovr_cmd | (uart_mode & rx_byte_valid & uart_unread);
   assign err_set[ERR_ABORT] = abort_set;
   // A break aborts the transfer on every node, error or not
   wire stop = ((|err_set) & ~uart_mode) | abort_set | (brk_detect & ~uart_mode);
   wire hdr_set = header_end & ~uart_mode;
   wire rx_set = (rx_ck_byte & ~ck_bad) | (uart_mode & rx_byte_valid);
   wire tx_set = (in_tx_rsp & tx_resp_end & ~stop)
                 | (state == ST_UART_TX & uart_tx_char);
   wire err_clr = clr_error | (uart_mode & dp_read);
   wire [3:0] len_clamp = (len_wdata[3:0] > LEN_MAX) ? LEN_MAX : len_wdata[3:0];
   wire [3:0] len_clamp_tx = (len_wdata[7:4] > LEN_MAX) ? LEN_MAX : len_wdata[7:4];
   wire [3:0] len_code = header_pid[5] ? (header_pid[4] ? LEN_8 : LEN_4) : LEN_2;
   wire [2:0] next_index = sel_write ? sel_index
                          : (lin_dp & ~autoinc_disable_n) ? buffer_index + 3'h1
                          : buffer_index;
   assign busy_flag = state != ST_IDLE;
   assign error_summary_flag = |error_flags_reg;
   assign irq_err = error_summary_flag & error_irq_enable;
   assign irq_tc = (header_done_flag & header_irq_enable) | (tx_done_flag & tx_irq_enable)
                   | (rx_done_flag & rx_irq_enable);
   assign tx_valid = fifo_cnt != 2'h0;
   assign tx_data = fifo_mem[rd_ptr];
   assign tx_abort = stop & tx_phase;
   assign dp_wr_ready = ~uart_mode | (~busy_flag & fifo_in_ready);
   // Flags: a set in the cycle of its clear wins
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         header_done_flag <= 1'b0;
         rx_done_flag <= 1'b0;
         tx_done_flag <= 1'b0;
         error_flags_reg <= 8'h00;
      end else begin
         header_done_flag <= hdr_set | (header_done_flag & ~clr_header_done);
         rx_done_flag <= rx_set | (rx_done_flag & ~clr_rx_done);
         tx_done_flag <= tx_set | (tx_done_flag & ~clr_tx_done);
         error_flags_reg <= err_set | (error_flags_reg & ~{8{err_clr}});
      end
   end
   // Command and transfer state
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
         command_field <= CMD_ABORT;
      end else if (stop) begin
         state <= ST_IDLE;
         command_field <= CMD_ABORT;
      end else if (cmd_start) begin
         command_field <= cmd_code;
         case (cmd_code)
            CMD_TX_HDR: state <= ST_TX_HDR;
            CMD_RX_RSP: state <= ST_RX_RSP;
            CMD_TX_RSP: state <= ST_TX_RSP;
            default: state <= ST_IDLE;
         endcase
      end else begin
         if (uart_mode & cmd_write & ~busy_flag) begin
            command_field <= cmd_code;
         end
         case (state)
            ST_IDLE: state <= uart_push ? ST_UART_TX : ST_IDLE;
            ST_TX_HDR: state <= header_end ? ST_IDLE : ST_TX_HDR;
            ST_RX_RSP: state <= rx_ck_byte ? ST_IDLE : ST_RX_RSP;
            ST_TX_RSP: state <= tx_resp_end ? ST_IDLE : ST_TX_RSP;
            ST_UART_TX: state <= uart_tx_char ? ST_IDLE : ST_UART_TX;
            default: state <= ST_IDLE;
         endcase
      end
   end
   // Header capture, lengths and identifier status
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pid <= 8'h00;
         id_status_field <= 3'h0;
         rx_length_field <= 4'h0;
         tx_length_field <= 4'h0;
      end else begin
         if (hdr_set) begin
            pid <= header_pid;
            id_status_field <= (header_pid[5:2] == ID_SPECIAL_HI) ?
                               {1'b1, header_pid[1:0]} : 3'h0;
         end
         if (uart_mode) begin
            rx_length_field <= 4'h0;
            tx_length_field <= 4'h0;
         end else if (hdr_set & classic_version_select) begin
            rx_length_field <= len_code;
            tx_length_field <= len_code;
         end else if (len_write & ~busy_flag) begin
            rx_length_field <= len_clamp;
            tx_length_field <= len_clamp_tx;
         end
      end
   end
   // Checksum accumulation and response counters
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sum <= 8'h00;
         rx_cnt <= 4'h0;
         feed_cnt <= 4'h0;
         ck_pushed <= 1'b0;
      end else if (cmd_start) begin
         sum <= classic_version_select ? 8'h00 : pid;
         rx_cnt <= 4'h0;
         feed_cnt <= 4'h0;
         ck_pushed <= 1'b0;
      end else if (rx_data_byte) begin
         sum <= add_carry(sum, rx_byte);
         rx_cnt <= rx_cnt + 4'h1;
      end else if (feed_push) begin
         if (feed_data) begin
            sum <= add_carry(sum, feed_byte);
            feed_cnt <= feed_cnt + 4'h1;
         end else begin
            ck_pushed <= 1'b1;
         end
      end
   end
   // Frame buffer and data port
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 8; i++) begin
            frame_buf[i] <= 8'h00;
         end
         buffer_index <= 3'h0;
         dp_rdata <= 8'h00;
         uart_rx_data <= 8'h00;
         uart_unread <= 1'b0;
      end else begin
         buffer_index <= next_index;
         if (rx_data_byte) begin
            frame_buf[rx_cnt[2:0]] <= rx_byte;
         end else if (dp_write & ~uart_mode & ~busy_flag) begin
            frame_buf[buffer_index] <= dp_wdata;
         end
         if (dp_read) begin
            dp_rdata <= uart_mode ? uart_rx_data : frame_buf[buffer_index];
         end
         if (uart_mode & rx_byte_valid) begin
            uart_rx_data <= rx_byte;
         end
         uart_unread <= (uart_mode & rx_byte_valid) | (uart_unread & ~(dp_read & uart_mode));
      end
   end
   // Frame timer starts once synch and identifier are on the bus
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         frame_wait <= 1'b0;
         to_cnt <= 16'h0000;
      end else if (hdr_set) begin
         frame_wait <= 1'b1;
         to_cnt <= 16'h0000;
      end else if (stop | rx_set | tx_set) begin
         frame_wait <= 1'b0;
      end else if (frame_wait & bit_tick) begin
         to_cnt <= to_cnt + 16'h0001;
      end
   end
   // Two-entry buffer toward the serializer; a stalled receiver holds the feed
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         fifo_mem[0] <= 8'h00;
         fifo_mem[1] <= 8'h00;
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         fifo_cnt <= 2'h0;
      end else if (stop) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         fifo_cnt <= 2'h0;
      end else begin
         if (fifo_push) begin
            fifo_mem[wr_ptr] <= fifo_wdata;
            wr_ptr <= ~wr_ptr;
         end
         if (fifo_pop) begin
            rd_ptr <= ~rd_ptr;
         end
         fifo_cnt <= fifo_cnt + {1'b0, fifo_push} - {1'b0, fifo_pop};
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   AST_HDR_SET: assert property (header_end && !uart_mode |=> header_done_flag)
      else $error("header done not set");
   AST_HDR_UART: assert property (uart_mode && !header_done_flag |=> !header_done_flag)
      else $error("header done driven in UART mode");
   AST_ERR_OR: assert property ($rose(error_summary_flag) |-> $past(|err_set))
      else $error("error summary rose without cause");
   AST_BIT: assert property (tx_bit_valid && tx_phase && !uart_mode && tx_bit_read != tx_bit_sent
      |=> error_flags_reg[ERR_BIT] && !busy_flag)
      else $error("bit error not flagged or send not aborted");
   AST_STOP: assert property ((|err_set) && !uart_mode
      |=> command_field == CMD_ABORT && state == ST_IDLE)
      else $error("no return to idle after error");
   AST_CLR: assert property (clr_error && err_set == 8'h00 |=> !error_summary_flag)
      else $error("error clear failed");
   AST_ABORT: assert property (cmd_write && busy_flag && cmd_code == CMD_ABORT
      |=> error_flags_reg[ERR_ABORT] && !busy_flag)
      else $error("abort flag not set");
   AST_OVR: assert property (cmd_write && busy_flag && cmd_code != CMD_ABORT
      |=> error_flags_reg[ERR_OVR])
      else $error("overrun not flagged");
   AST_IDST: assert property (header_end && !uart_mode && header_pid[5:2] == ID_SPECIAL_HI
      |=> id_status_field == {1'b1, $past(header_pid[1:0])})
      else $error("identifier status wrong");
   AST_IDX: assert property (lin_dp && !autoinc_disable_n && !sel_write
      |=> buffer_index == 3'($past(buffer_index) + 3'h1))
      else $error("index did not advance");
   AST_HOLD: assert property (rx_done_flag && !clr_rx_done |=> rx_done_flag)
      else $error("rx done lost without clear");
   COV_TX_RSP: cover property (in_tx_rsp ##[1:300] tx_done_flag);
   COV_RX_OK: cover property (rx_ck_byte && !ck_bad);
   COV_BRK: cover property (slave_brk && in_rx);
   COV_STALL: cover property (fifo_cnt == 2'h2 && !tx_ready);
endmodule : lsebf_core

/* File: sim/lsebf_partner.sv */
// Serializer stand-in: takes tx bytes through tx_valid/tx_ready, logs them.
// Assumes one clock; the bench sets stall, clr and the byte count of a response.
`timescale 1ns/100ps
module lsebf_partner (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic stall,
   input wire logic clr,
   input wire logic [3:0] expect_n,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic tx_resp_end,
   output logic all_in,
   output logic [71:0] got
);
   logic [3:0] cnt;
   assign all_in = (cnt == expect_n);
   // Ready only every other cycle, so the buffer also meets a slow reader
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 4'h0;
         tx_ready <= 1'b0;
         tx_resp_end <= 1'b0;
         got <= '0;
      end else begin
         tx_ready <= !stall && !tx_ready;
         tx_resp_end <= 1'b0;
         if (clr) begin
            cnt <= 4'h0;
         end else if (tx_valid && tx_ready) begin
            got[cnt*8 +: 8] <= tx_data;
            cnt <= cnt + 4'h1;
            tx_resp_end <= (cnt + 4'h1 == expect_n);
         end
      end
   end
endmodule : lsebf_partner

/* File: sim/testbench.sv */
// Self-checking bench for the status, error, checksum and buffer block.
// Assumes lsebf_pkg, lsebf_core and the serializer stand-in lsebf_partner.
`timescale 1ns/100ps
module testbench;
   import lsebf_pkg::*;
   localparam int TO_BITS = 10;
   logic sys_clk, arst_n, uart_mode, master_mode, classic_version_select, cmd_write;
   logic len_write, sel_write, autoinc_disable_n, dp_write, dp_read, clr_header_done;
   logic clr_rx_done, clr_tx_done, clr_error, error_irq_enable, header_irq_enable;
   logic tx_irq_enable, rx_irq_enable, header_end, sync_bad, brk_detect, bit_tick;
   logic tx_bit_valid, tx_bit_sent, tx_bit_read, stop_valid, stop_level, rx_byte_valid;
   logic tx_resp_end, uart_tx_char, tx_ready, tx_valid, tx_abort, dp_wr_ready;
   logic header_done_flag, rx_done_flag, tx_done_flag, error_summary_flag, busy_flag;
   logic irq_err, irq_tc, stall, clr, all_in;
   logic [2:0] cmd_code, sel_index, id_status_field, command_field, buffer_index;
   logic [7:0] len_wdata, dp_wdata, header_pid, rx_byte, tx_data, dp_rdata, error_flags_reg;
   logic [3:0] rx_length_field, tx_length_field, expect_n;
   logic [71:0] got;
   int num_errors, samples_checked, aborts;
   lsebf_core #(.TIMEOUT_BITS(TO_BITS)) lsebf_core_inst (.*);
   lsebf_partner lsebf_partner_inst (.*);
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // The abort output is a one-cycle pulse, so it is counted for later judging
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         aborts <= 0;
      end else if (tx_abort === 1'b1) begin
         aborts <= aborts + 1;
      end
   end
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask : tick
   // Idle cycle after each strobe keeps a driver from assigning twice per step
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick();
      s = 1'b0;
      tick();
   endtask : pulse
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wait_for(ref logic s, input logic v);
      for (int i = 0; i < 200 && s !== v; i++) tick();
      check(s, v);
   endtask : wait_for
   task automatic cmd(input logic [2:0] c);
      cmd_code = c;
      pulse(cmd_write);
   endtask : cmd
   task automatic rxb(input logic [7:0] b);
      rx_byte = b;
      pulse(rx_byte_valid);
   endtask : rxb
   function automatic logic [7:0] pid_of(input logic [5:0] id);
      return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
   endfunction : pid_of
   function automatic logic [7:0] add_c(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = a + b;
      return s[7:0] + {7'h0, s[8]};
   endfunction : add_c
   task automatic finish_test();
      $display("Comparisons %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test
   task automatic t_header();
      logic [5:0] id;
      for (int i = 0; i < 5; i++) begin
         id = (i < 4) ? 6'h3C + 6'(i) : 6'h15;
         header_pid = pid_of(id);
         pulse(header_end);
         check(header_done_flag, 1'b1);
         check(irq_tc, 1'b1);
         check(id_status_field & {1'b1, {2{i < 4}}}, (i < 4) ? {1'b1, id[1:0]} : 3'h0);
         check(error_flags_reg, 8'h00);
         header_irq_enable = 1'b0;
         tick();
         check(irq_tc, 1'b0);
         header_irq_enable = 1'b1;
         pulse(clr_header_done);
         check(header_done_flag, 1'b0);
      end
      header_pid = pid_of(6'h15) ^ 8'h40;
      pulse(header_end);
      check(error_flags_reg[ERR_PAR], 1'b1);
      check(irq_err, 1'b1);
      pulse(clr_error);
      check(error_summary_flag, 1'b0);
      pulse(clr_header_done);
   endtask : t_header
   task automatic t_tx();
      logic [7:0] d [5] = '{8'h66, 8'h77, 8'hA1, 8'hB2, 8'hC3};
      logic [7:0] s;
      header_pid = pid_of(6'h15);
      pulse(header_end);
      pulse(clr_header_done);
      len_wdata = 8'h30;
      pulse(len_write);
      sel_index = 3'h6;
      pulse(sel_write);
      for (int i = 0; i < 5; i++) begin
         dp_wdata = d[i];
         pulse(dp_write);
      end
      check(buffer_index, 3'h3);
      s = header_pid;
      for (int i = 2; i < 5; i++) s = add_c(s, d[i]);
      stall = 1'b1;
      expect_n = 4'h4;
      pulse(clr);
      cmd(CMD_TX_RSP);
      check(busy_flag, 1'b1);
      repeat (4) tick();
      check(tx_valid, 1'b1);
      stall = 1'b0;
      wait_for(all_in, 1'b1);
      check(got[31:16], {~s, d[4]});
      check(got[15:0], {d[3], d[2]});
      wait_for(tx_done_flag, 1'b1);
      check(busy_flag, 1'b0);
      check(irq_tc, 1'b1);
      pulse(clr_tx_done);
   endtask : t_tx
   task automatic t_busy();
      int n;
      stall = 1'b1;
      pulse(clr);
      cmd(CMD_TX_RSP);
      cmd(CMD_RX_RSP);
      check(error_flags_reg[ERR_OVR], 1'b1);
      check(busy_flag, 1'b0);
      cmd(CMD_TX_RSP);
      cmd(CMD_ABORT);
      wait_for(busy_flag, 1'b0);
      check(error_flags_reg, 8'hC0);
      check(error_summary_flag, 1'b1);
      // Master recovery: abort first, then a fresh header
      cmd(CMD_TX_HDR);
      check(busy_flag, 1'b1);
      pulse(header_end);
      check(busy_flag, 1'b0);
      pulse(clr_error);
      check(error_flags_reg, 8'h00);
      pulse(clr_header_done);
      n = aborts;
      cmd(CMD_TX_RSP);
      tx_bit_sent = 1'b1;
      tx_bit_read = 1'b1;
      pulse(tx_bit_valid);
      check(error_flags_reg, 8'h00);
      tx_bit_read = 1'b0;
      pulse(tx_bit_valid);
      check(error_flags_reg[ERR_BIT], 1'b1);
      check(16'(aborts - n), 16'h0001);
      check({busy_flag, command_field}, {1'b0, CMD_ABORT});
      pulse(clr_error);
   endtask : t_busy
   task automatic t_rx();
      classic_version_select = 1'b1;
      header_pid = pid_of(6'h0A);
      pulse(header_end);
      check({rx_length_field, tx_length_field}, 8'h22);
      for (int k = 0; k < 2; k++) begin
         cmd(CMD_RX_RSP);
         rxb(8'h11);
         rxb(8'h22);
         rxb(8'hCC + 8'(k));
         check(rx_done_flag, k == 0);
         check(error_flags_reg[ERR_CK], k == 1);
         check(busy_flag, 1'b0);
         pulse(clr_rx_done);
         pulse(clr_error);
      end
      sel_index = 3'h0;
      pulse(sel_write);
      pulse(dp_read);
      check(dp_rdata, 8'h11);
      pulse(dp_read);
      check(dp_rdata, 8'h22);
      master_mode = 1'b1;
      pulse(sync_bad);
      check(error_flags_reg[ERR_SYNC], 1'b0);
      cmd(CMD_RX_RSP);
      pulse(brk_detect);
      check({busy_flag, error_flags_reg}, 9'h000);
      master_mode = 1'b0;
      classic_version_select = 1'b0;
      pulse(sync_bad);
      check(error_flags_reg[ERR_SYNC], 1'b1);
      pulse(clr_error);
      len_wdata = 8'h88;
      pulse(len_write);
      pulse(header_end);
      cmd(CMD_RX_RSP);
      repeat (TO_BITS + 2) pulse(bit_tick);
      check(error_flags_reg[ERR_TO], 1'b1);
      check(busy_flag, 1'b0);
      pulse(clr_error);
      cmd(CMD_RX_RSP);
      rxb(8'h5A);
      pulse(brk_detect);
      check(error_flags_reg, 8'h01 << ERR_FRM);
      check(busy_flag, 1'b0);
      pulse(clr_error);
      cmd(CMD_TX_RSP);
      pulse(brk_detect);
      check(error_flags_reg, 8'h01 << ERR_BIT);
      pulse(clr_error);
      pulse(clr_header_done);
   endtask : t_rx
   task automatic t_uart();
      uart_mode = 1'b1;
      pulse(header_end);
      check(header_done_flag, 1'b0);
      rxb(8'h5A);
      check(rx_done_flag, 1'b1);
      rxb(8'hA5);
      check(error_flags_reg[ERR_OVR], 1'b1);
      stop_level = DOMINANT;
      pulse(stop_valid);
      check(error_flags_reg[ERR_FRM], 1'b1);
      pulse(dp_read);
      check(dp_rdata, 8'hA5);
      check(error_summary_flag, 1'b0);
      stall = 1'b1;
      expect_n = 4'h1;
      pulse(clr);
      cmd(3'h5);
      check(dp_wr_ready, 1'b1);
      dp_wdata = 8'h3E;
      pulse(dp_write);
      check({busy_flag, dp_wr_ready}, 2'h2);
      // A write while busy must be refused, not queued behind the first
      dp_wdata = 8'h77;
      pulse(dp_write);
      stall = 1'b0;
      wait_for(all_in, 1'b1);
      repeat (6) tick();
      check({all_in, got[7:0]}, 9'h13E);
      pulse(uart_tx_char);
      check({tx_done_flag, busy_flag}, 2'h2);
      uart_mode = 1'b0;
   endtask : t_uart
   initial begin
      {uart_mode, master_mode, classic_version_select, cmd_write, len_write, sel_write} = '0;
      {autoinc_disable_n, dp_write, dp_read, clr_header_done, clr_rx_done, clr_tx_done} = '0;
      {clr_error, header_end, sync_bad, brk_detect, bit_tick, tx_bit_valid, stop_valid} = '0;
      {tx_bit_sent, tx_bit_read, rx_byte_valid, uart_tx_char, stall, clr} = '0;
      {cmd_code, sel_index, len_wdata, dp_wdata, header_pid, rx_byte, expect_n} = '0;
      {error_irq_enable, header_irq_enable, tx_irq_enable, rx_irq_enable} = 4'hF;
      stop_level = 1'b1;
      arst_n = 1'b0;
      repeat (16) @(posedge sys_clk);
      #1;
      arst_n = 1'b1;
      check({busy_flag, error_summary_flag, command_field}, 5'h00);
      check({tx_valid, dp_wr_ready, irq_err, irq_tc}, 4'h4);
      t_header();
      t_tx();
      t_busy();
      t_rx();
      t_uart();
      finish_test();
   end
   // Whole run needs a few hundred cycles; this bound only cuts a hang
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      finish_test();
   end
endmodule : testbench
